// ==== include/lsra_map.svh ====
`ifndef LSRA_MAP_SVH
`define LSRA_MAP_SVH
// register indices reached through the command byte
`define LSRA_REG_CONTROL     5'h00
`define LSRA_REG_INT_TIME    5'h02
`define LSRA_REG_RES_LOW     5'h14
`define LSRA_REG_RES_MID     5'h15
`define LSRA_REG_RES_HIGH    5'h16
// field positions
`define LSRA_CTL_POWER_BIT   0
`define LSRA_CTL_CONV_EN_BIT 1
`define LSRA_CTL_VALID_BIT   4
`define LSRA_CMD_FLAG_BIT    7
// reset values
`define LSRA_CONTROL_RESET   8'h00
`define LSRA_INT_TIME_RESET  8'hff
`define LSRA_RESULT_RESET    20'h00000
// seven-bit bus addresses for pin low, high and floating
`define LSRA_ADDR_PIN_LOW    7'h54
`define LSRA_ADDR_PIN_HIGH   7'h2b
`define LSRA_ADDR_PIN_FLOAT  7'h1a
// timing
`define LSRA_INT_STEP_MS     5
`define LSRA_CLK_PERIOD_NS   8
`define LSRA_INT_STEP_CYC    (`LSRA_INT_STEP_MS * 1000000 / `LSRA_CLK_PERIOD_NS)
`endif

// ==== include/lsra_pkg.sv ====
`default_nettype none
package lsra_pkg;
    typedef enum logic [2:0] {
        LSRA_IDLE = 3'h0,
        LSRA_ADDR = 3'h1,
        LSRA_AACK = 3'h3,
        LSRA_RX   = 3'h2,
        LSRA_RACK = 3'h6,
        LSRA_TX   = 3'h7,
        LSRA_TACK = 3'h5
    } lsra_st_t;

    typedef struct packed {
        logic        valid;
        logic [19:0] value;
    } lsra_result_t;

    typedef struct packed {
        logic [19:0]  step;
        logic [7:0]   periods;
        lsra_result_t res;
    } lsra_conv_t;

    typedef struct packed {
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_prev;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_prev;
        logic [1:0]  asel_s1;
        logic [1:0]  asel_s2;
        lsra_st_t    st;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic        rw;
        logic        first;
        logic [4:0]  ptr;
        logic        sda_oe_n;
        logic        power;
        logic        conversion_enable_bit;
        logic [7:0]  integration_time_register;
    } lsra_i2c_t;
endpackage : lsra_pkg
`default_nettype wire

// ==== core/lsra_conv.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lsra_map.svh"
module lsra_conv #(
    parameter int unsigned STEP_CYCLES = `LSRA_INT_STEP_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  power,
    input  wire logic                  conversion_enable_bit,
    input  wire logic [7:0]            integration_time_register,
    input  wire logic [19:0]           light_sample,
    output var lsra_pkg::lsra_result_t result
);
    lsra_pkg::lsra_conv_t q_ff;
    lsra_pkg::lsra_conv_t nxt_q;
    logic                 run;
    logic                 step_end;
    logic                 done;

    assign run      = power & conversion_enable_bit;
    assign step_end = q_ff.step == 20'(STEP_CYCLES - 1);
    assign done     = run && step_end && (integration_time_register != 8'h00) &&
                      (q_ff.periods == integration_time_register - 8'h01);

    always_comb begin
        nxt_q = q_ff;
        if (!run) begin
            nxt_q.step      = 20'h00000;
            nxt_q.periods   = 8'h00;
            nxt_q.res.valid = 1'b0;
        end else if (step_end) begin
            nxt_q.step    = 20'h00000;
            nxt_q.periods = done ? 8'h00 : q_ff.periods + 8'h01;
        end else begin
            nxt_q.step = q_ff.step + 20'h00001;
        end
        if (done) begin
            nxt_q.res.value = light_sample;
            nxt_q.res.valid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_ff <= '{step: 20'h00000, periods: 8'h00, res: '{valid: 1'b0, value: `LSRA_RESULT_RESET}};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign result = q_ff.res;

    chk_result_coherent: assert property (@(posedge clk) disable iff (!rst_n)
        !done |=> $stable(q_ff.res.value)) else $error("result changed outside integration end");
    chk_idle_no_valid: assert property (@(posedge clk) disable iff (!rst_n)
        !(power && conversion_enable_bit) |=> !q_ff.res.valid && q_ff.step == 20'h00000)
        else $error("conversion while off");
    chk_result_reset: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> q_ff.res.value == 20'h00000) else $error("result not zero after reset");
endmodule : lsra_conv
`default_nettype wire

// ==== core/lsra_top.sv ====
// Summary of operation
// - the 20-bit result reads as low byte, middle byte and a high byte holding bits 19:16 with 7:4 zero.
// - the three result registers are read-only and are zero after power-up.
// - the device starts powered down and does not convert until powered up.
// - the bus address is 0xA8/0xA9 with the select pin low, 0x56/0x57 high, 0x34/0x35 floating.
// - a write is start, write address, command byte with bit 7 set, data, stop, every byte acknowledged.
// - a read is start, write address, command, repeated start, read address, data bytes ending in a nack and stop.
// - a burst read from the low result register returns low, middle and high bytes in order.
// - the first byte after the write address is a command byte when its bit 7 is set, and its low five bits pick the register.
// - bytes after the command byte are data for the addressed register.
`timescale 1ns/1ps
`default_nettype none
`include "lsra_map.svh"
module lsra_top #(
    parameter int unsigned STEP_CYCLES = `LSRA_INT_STEP_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic [1:0]  address_select_pin,
    input  wire logic [19:0] light_sample,
    output logic             conv_running
);
    lsra_pkg::lsra_i2c_t    q_ff;
    lsra_pkg::lsra_i2c_t    nxt_q;
    lsra_pkg::lsra_result_t result;
    logic [6:0]             own_addr;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   bus_start;
    logic                   bus_stop;
    logic                   rx_byte_done;
    logic                   tx_load;
    logic [7:0]             tx_byte;
    localparam logic [7:0]  CTL_RESET = `LSRA_CONTROL_RESET;

    // byte view of the result and control
    function automatic logic [7:0] rd_byte(input logic [4:0] idx, input lsra_pkg::lsra_i2c_t s,
                                           input lsra_pkg::lsra_result_t r);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            `LSRA_REG_CONTROL: begin
                b[`LSRA_CTL_POWER_BIT]   = s.power;
                b[`LSRA_CTL_CONV_EN_BIT] = s.conversion_enable_bit;
                b[`LSRA_CTL_VALID_BIT]   = r.valid;
            end
            `LSRA_REG_INT_TIME: b = s.integration_time_register;
            `LSRA_REG_RES_LOW:  b = r.value[7:0];
            `LSRA_REG_RES_MID:  b = r.value[15:8];
            `LSRA_REG_RES_HIGH: b = {4'h0, r.value[19:16]};
            default:            b = 8'h00;
        endcase
        return b;
    endfunction : rd_byte

    lsra_conv #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_conv (
        .clk                       (clk),
        .rst_n                     (rst_n),
        .power                     (q_ff.power),
        .conversion_enable_bit     (q_ff.conversion_enable_bit),
        .integration_time_register (q_ff.integration_time_register),
        .light_sample              (light_sample),
        .result                    (result)
    );

    // bus address from the select pin
    always_comb begin
        if (q_ff.asel_s2[1]) begin
            own_addr = `LSRA_ADDR_PIN_FLOAT;
        end else if (q_ff.asel_s2[0]) begin
            own_addr = `LSRA_ADDR_PIN_HIGH;
        end else begin
            own_addr = `LSRA_ADDR_PIN_LOW;
        end
    end

    assign scl_rise     = q_ff.scl_s2 & ~q_ff.scl_prev;
    assign scl_fall     = ~q_ff.scl_s2 & q_ff.scl_prev;
    assign bus_start    = q_ff.scl_s2 & q_ff.scl_prev & q_ff.sda_prev & ~q_ff.sda_s2;
    assign bus_stop     = q_ff.scl_s2 & q_ff.scl_prev & ~q_ff.sda_prev & q_ff.sda_s2;
    assign rx_byte_done = (q_ff.st == lsra_pkg::LSRA_RX) && scl_fall && (q_ff.cnt == 4'h8);
    assign tx_load      = scl_fall && ((q_ff.st == lsra_pkg::LSRA_AACK && q_ff.rw) ||
                                       (q_ff.st == lsra_pkg::LSRA_TACK));
    assign tx_byte      = rd_byte(q_ff.ptr, q_ff, result);

    always_comb begin
        nxt_q          = q_ff;
        nxt_q.scl_s1   = scl_in;
        nxt_q.scl_s2   = q_ff.scl_s1;
        nxt_q.scl_prev = q_ff.scl_s2;
        nxt_q.sda_s1   = sda_in;
        nxt_q.sda_s2   = q_ff.sda_s1;
        nxt_q.sda_prev = q_ff.sda_s2;
        nxt_q.asel_s1  = address_select_pin;
        nxt_q.asel_s2  = q_ff.asel_s1;
        if (bus_stop) begin
            nxt_q.st       = lsra_pkg::LSRA_IDLE;
            nxt_q.sda_oe_n = 1'b1;
        end else if (bus_start) begin
            nxt_q.st       = lsra_pkg::LSRA_ADDR;
            nxt_q.cnt      = 4'h0;
            nxt_q.sda_oe_n = 1'b1;
        end else begin
            unique case (q_ff.st)
                lsra_pkg::LSRA_IDLE: begin
                    nxt_q.sda_oe_n = 1'b1;
                end
                lsra_pkg::LSRA_ADDR: begin
                    if (scl_rise) begin
                        nxt_q.sh  = {q_ff.sh[6:0], q_ff.sda_s2};
                        nxt_q.cnt = q_ff.cnt + 4'h1;
                    end else if (scl_fall && q_ff.cnt == 4'h8) begin
                        if (q_ff.sh[7:1] == own_addr) begin
                            nxt_q.st       = lsra_pkg::LSRA_AACK;
                            nxt_q.rw       = q_ff.sh[0];
                            nxt_q.sda_oe_n = 1'b0;
                        end else begin
                            nxt_q.st = lsra_pkg::LSRA_IDLE;
                        end
                    end
                end
                lsra_pkg::LSRA_AACK: begin
                    if (scl_fall) begin
                        nxt_q.cnt = 4'h0;
                        if (q_ff.rw) begin
                            // read data starts at the pointer
                            nxt_q.st       = lsra_pkg::LSRA_TX;
                            nxt_q.sh       = tx_byte;
                            nxt_q.sda_oe_n = tx_byte[7];
                            nxt_q.ptr      = q_ff.ptr + 5'h01;
                        end else begin
                            nxt_q.st       = lsra_pkg::LSRA_RX;
                            nxt_q.first    = 1'b1;
                            nxt_q.sda_oe_n = 1'b1;
                        end
                    end
                end
                lsra_pkg::LSRA_RX: begin
                    if (scl_rise) begin
                        nxt_q.sh  = {q_ff.sh[6:0], q_ff.sda_s2};
                        nxt_q.cnt = q_ff.cnt + 4'h1;
                    end else if (rx_byte_done) begin
                        nxt_q.st       = lsra_pkg::LSRA_RACK;
                        nxt_q.sda_oe_n = 1'b0;
                        nxt_q.first    = 1'b0;
                        if (q_ff.first && q_ff.sh[`LSRA_CMD_FLAG_BIT]) begin
                            nxt_q.ptr = q_ff.sh[4:0];
                        end else begin
                            // data byte for the addressed register
                            unique case (q_ff.ptr)
                                `LSRA_REG_CONTROL: begin
                                    nxt_q.power                 = q_ff.sh[`LSRA_CTL_POWER_BIT];
                                    nxt_q.conversion_enable_bit = q_ff.sh[`LSRA_CTL_CONV_EN_BIT];
                                end
                                `LSRA_REG_INT_TIME: nxt_q.integration_time_register = q_ff.sh;
                                // result and unmapped registers ignore writes
                                default: nxt_q.integration_time_register = q_ff.integration_time_register;
                            endcase
                            nxt_q.ptr = q_ff.ptr + 5'h01;
                        end
                    end
                end
                lsra_pkg::LSRA_RACK: begin
                    if (scl_fall) begin
                        nxt_q.st       = lsra_pkg::LSRA_RX;
                        nxt_q.cnt      = 4'h0;
                        nxt_q.sda_oe_n = 1'b1;
                    end
                end
                lsra_pkg::LSRA_TX: begin
                    if (scl_rise) begin
                        nxt_q.cnt = q_ff.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q_ff.cnt == 4'h8) begin
                            nxt_q.st       = lsra_pkg::LSRA_TACK;
                            nxt_q.sda_oe_n = 1'b1;
                        end else begin
                            nxt_q.sh       = {q_ff.sh[6:0], 1'b0};
                            nxt_q.sda_oe_n = q_ff.sh[6];
                        end
                    end
                end
                lsra_pkg::LSRA_TACK: begin
                    // a nack from the master ends the read
                    if (scl_rise && q_ff.sda_s2) begin
                        nxt_q.st = lsra_pkg::LSRA_IDLE;
                    end else if (scl_fall) begin
                        // next byte in the same read
                        nxt_q.st       = lsra_pkg::LSRA_TX;
                        nxt_q.cnt      = 4'h0;
                        nxt_q.sh       = tx_byte;
                        nxt_q.sda_oe_n = tx_byte[7];
                        nxt_q.ptr      = q_ff.ptr + 5'h01;
                    end
                end
                default: begin
                    nxt_q.st       = lsra_pkg::LSRA_IDLE;
                    nxt_q.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_ff          <= '0;
            q_ff.scl_s1   <= 1'b1;
            q_ff.scl_s2   <= 1'b1;
            q_ff.scl_prev <= 1'b1;
            q_ff.sda_s1   <= 1'b1;
            q_ff.sda_s2   <= 1'b1;
            q_ff.sda_prev <= 1'b1;
            q_ff.st       <= lsra_pkg::LSRA_IDLE;
            q_ff.sda_oe_n <= 1'b1;
            q_ff.power    <= CTL_RESET[`LSRA_CTL_POWER_BIT];
            q_ff.conversion_enable_bit     <= CTL_RESET[`LSRA_CTL_CONV_EN_BIT];
            q_ff.integration_time_register <= `LSRA_INT_TIME_RESET;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign sda_out      = 1'b0;
    assign sda_oe_n     = q_ff.sda_oe_n;
    assign conv_running = q_ff.power & q_ff.conversion_enable_bit;

    sequence s_tx_end;
        (q_ff.st == lsra_pkg::LSRA_TX) ##1 (q_ff.st == lsra_pkg::LSRA_TACK);
    endsequence

    chk_high_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        tx_load && q_ff.ptr == `LSRA_REG_RES_HIGH |=> q_ff.sh == {4'h0, $past(result.value[19:16])})
        else $error("high result byte wrong");
    chk_addr_match: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(q_ff.st == lsra_pkg::LSRA_AACK) |-> q_ff.sh[7:1] == own_addr) else $error("acked foreign address");
    chk_ack_driven: assert property (@(posedge clk) disable iff (!rst_n)
        rx_byte_done |=> !sda_oe_n [*2]) else $error("received byte not acknowledged");
    chk_cmd_pointer: assert property (@(posedge clk) disable iff (!rst_n)
        rx_byte_done && q_ff.first && q_ff.sh[7] |=> q_ff.ptr == $past(q_ff.sh[4:0])) else $error("command lost");
    chk_data_step: assert property (@(posedge clk) disable iff (!rst_n)
        rx_byte_done && !q_ff.first |=> q_ff.ptr == $past(q_ff.ptr) + 5'h01) else $error("write pointer stuck");
    chk_master_ack_free: assert property (@(posedge clk) disable iff (!rst_n)
        s_tx_end |-> sda_oe_n) else $error("bus held during master ack");
    chk_read_order: assert property (@(posedge clk) disable iff (!rst_n)
        tx_load |=> q_ff.ptr == $past(q_ff.ptr) + 5'h01 && q_ff.sh == $past(tx_byte))
        else $error("read byte out of order");
endmodule : lsra_top
`default_nettype wire

// ==== tb/lsra_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsra_host #(
    parameter real QTR_NS = 31.25,
    parameter real GAP_NS = 1600.0
) (
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start_c();
        #(QTR_NS) sda_drv = 1'b1;
        #(QTR_NS) scl = 1'b1;
        #(QTR_NS) sda_drv = 1'b0;
        #(QTR_NS) scl = 1'b0;
    endtask : start_c
    task automatic stop_c();
        #(QTR_NS) sda_drv = 1'b0;
        #(QTR_NS) scl = 1'b1;
        #(QTR_NS) sda_drv = 1'b1;
        #(QTR_NS);
    endtask : stop_c
    // one bit per 125 ns, data changed mid low phase
    task automatic bit_c(input logic b, output logic s);
        #(QTR_NS) sda_drv = b;
        #(QTR_NS) scl = 1'b1;
        #(QTR_NS) s = sda_line;
        #(QTR_NS) scl = 1'b0;
    endtask : bit_c
    task automatic byte_c(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(tx[i], s);
            rx[i] = s;
        end
        bit_c(mack, ack);
    endtask : byte_c
    task automatic wr(input logic [7:0] aw, input logic [7:0] cmd, input int n, input logic [23:0] d,
                      output logic ok);
        logic [7:0] r;
        logic       a;
        start_c();
        byte_c(aw, 1'b1, r, a);
        ok = ~a;
        if (ok) begin
            byte_c(cmd, 1'b1, r, a);
            ok = ok & ~a;
            for (int i = 0; i < n; i++) begin
                byte_c(d[8*i +: 8], 1'b1, r, a);
                ok = ok & ~a;
            end
        end
        stop_c();
        #(GAP_NS);
    endtask : wr
    // read: command, repeated start, data with final nack
    task automatic rd(input logic [7:0] aw, input logic [7:0] cmd, input int n, output logic [23:0] q,
                      output logic ok);
        logic [7:0] r;
        logic       a;
        q = 24'h000000;
        start_c();
        byte_c(aw, 1'b1, r, a);
        ok = ~a;
        byte_c(cmd, 1'b1, r, a);
        ok = ok & ~a;
        start_c();
        byte_c(aw | 8'h01, 1'b1, r, a);
        ok = ok & ~a;
        for (int i = 0; i < n; i++) begin
            byte_c(8'hff, (i == n - 1), r, a);
            q[8*i +: 8] = r;
        end
        stop_c();
        #(GAP_NS);
    endtask : rd
endmodule : lsra_host
`default_nettype wire

// ==== tb/light_sensor_result_access_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module light_sensor_result_access_tb_top;
    localparam int STEP = 4;
    logic        clk;
    logic        rst_n;
    logic [1:0]  asel;
    logic [19:0] sample;
    logic        sda_out;
    logic        sda_oe_n;
    logic        conv_running;
    logic        scl;
    logic        sda_drv;
    wire logic   sda_line;
    logic [23:0] q;
    logic        ok;
    logic [7:0]  wa;
    int          miscompares;
    int          n_compared;
    int          m_pow, m_en, m_valid, m_int_time, m_res, s;
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    lsra_top #(.STEP_CYCLES(STEP)) dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_pin(asel), .light_sample(sample),
        .conv_running(conv_running));
    lsra_host host (.sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    always #4 clk = ~clk;
    task automatic wrap_up();
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset(input int n);
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (n) @(posedge clk);
        #1 rst_n = 1'b1;
        {m_pow, m_en, m_valid, m_res} = '0;
        m_int_time = 255;
        repeat (4) @(posedge clk);
        #1 chk(24'(sda_oe_n), 24'h1);
    endtask : do_reset
    // model of the register file: pointer steps per data byte, result bytes ignored
    task automatic wreg(input logic [7:0] cmd, input int n, input logic [23:0] d);
        int p;
        host.wr(wa, cmd, n, d, ok);
        chk(24'(ok), 24'h1);
        p = cmd[4:0];
        for (int i = 0; i < n; i++) begin
            if (p == 0) {m_en, m_pow} = {int'(d[8*i+1]), int'(d[8*i])};
            if (p == 2) m_int_time = d[8*i +: 8];
            p = (p + 1) % 32;
        end
        if (m_pow == 0 || m_en == 0) m_valid = 0;
        else if (m_int_time * STEP < 150) {m_valid, m_res} = {32'd1, 12'h0, sample};
        chk(24'(conv_running), 24'(m_pow & m_en));
    endtask : wreg
    task automatic rreg(input logic [7:0] cmd, input int n, input logic [23:0] exp);
        host.rd(wa, cmd, n, q, ok);
        chk(24'(ok), 24'h1);
        chk(q, exp);
    endtask : rreg
    function automatic logic [23:0] ctl();
        return 24'(m_valid * 16 + m_en * 2 + m_pow);
    endfunction : ctl
    task automatic set_sample(input logic [19:0] v);
        @(posedge clk);
        #1 sample = v;
        repeat (20) @(posedge clk);
        if (m_pow != 0 && m_en != 0) {m_valid, m_res} = {32'd1, 12'h0, v};
    endtask : set_sample
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        asel = 2'b00;
        sample = 20'h00000;
        miscompares = 0;
        n_compared = 0;
        wa = 8'ha8;
        s = $urandom(73205);
        do_reset(12);
        // each pin setting answers its own address only
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            #1 asel = (k == 0) ? 2'b00 : (k == 1) ? 2'b01 : 2'b10;
            wa = (k == 0) ? 8'ha8 : (k == 1) ? 8'h56 : 8'h34;
            repeat (4) @(posedge clk);
            host.wr((k == 2) ? 8'ha8 : 8'h34, 8'h80, 0, 24'h0, ok);
            chk(24'(ok), 24'h0);
            rreg(8'h80, 1, ctl());
        end
        rreg(8'h94, 3, 24'h0);
        // powered but not enabled: no conversion
        set_sample(20'(($urandom % 20'hffffe) + 1));
        wreg(8'h80, 1, 24'h000001);
        rreg(8'h94, 3, 24'h0);
        // burst write: control, ignored reg, integration time
        wreg(8'h80, 3, 24'h015a01);
        rreg(8'h82, 1, 24'h01);
        rreg(8'h80, 1, ctl());
        wreg(8'h80, 1, 24'h000003);
        for (int i = 0; i < 3; i++) begin
            set_sample((i == 0) ? 20'hfffff : 20'($urandom));
            rreg(8'h94, 3, 24'(m_res));
            rreg(8'h80, 1, ctl());
        end
        wreg(8'h94, 3, 24'h123456);
        rreg(8'h94, 3, 24'(m_res));
        rreg(8'h95, 2, 24'(m_res >> 8));
        // disable clears valid
        wreg(8'h80, 1, 24'h000001);
        rreg(8'h80, 1, ctl());
        do_reset(2);
        rreg(8'h94, 3, 24'h0);
        rreg(8'h80, 1, ctl());
        rreg(8'h82, 1, 24'hff);
        wrap_up();
    end
endmodule : light_sensor_result_access_tb_top
`default_nettype wire
